// [hw/efh_readout.sv]
`timescale 1ns/10ps
`include "efh_regs.svh"
module efh_readout
  import efh_pkg::*;
#(
  parameter int BUF_WORDS = 128
)
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire efh_cap_t      cap_state,
  input  wire efh_hdr_t      hdr,
  input  wire logic [31:0]   main_fault,
  input  wire logic [31:0]   factory_fault,
  input  wire efh_stamp_t    now,
  output efh_samp_req_t      samp_req,
  input  wire logic [15:0]   samp_rdata,
  output logic               irq
);
  // --------------------------------------------------------------------
  // Parameter check
  // --------------------------------------------------------------------
  if (BUF_WORDS < `EFH_NUM_FAULTS || BUF_WORDS > 255) begin : g_bad_buf
    $error("BUF_WORDS must lie between 64 and 255.");
  end

  localparam logic [7:0] BUF_LEN = 8'(BUF_WORDS);

  typedef struct packed {
    efh_eng_t                          eng;
    efh_kind_t                         kind;
    efh_kind_t                         pkind;
    logic                              pend;
    logic [7:0]                        k;
    logic [7:0]                        len;
    logic [7:0]                        pk;
    logic [7:0]                        cnt_first;
    logic [15:0]                       samp_no;
    logic [15:0]                       hidx;
    logic [`EFH_IRQ_BITS-1:0]          irq_st;
    logic [`EFH_IRQ_BITS-1:0]          irq_msk;
    logic                              cap_done_q;
    logic                              fresh;
    logic [31:0]                       prdata;
    logic [BUF_WORDS-1:0][15:0]        bufw;
  } efh_rd_state_t;

  localparam efh_rd_state_t ST_RST = '{
    eng:     EFH_ENG_IDLE,
    kind:    EFH_LD_HDR,
    pkind:   EFH_LD_HDR,
    hidx:    `EFH_RST_HIST_IDX,
    irq_msk: `EFH_RST_IRQ_MASK,
    default: '0
  };

  efh_rd_state_t st;
  efh_rd_state_t next_st;

  // --------------------------------------------------------------------
  // Per-fault counters and histories
  // --------------------------------------------------------------------
  logic [`EFH_NUM_FAULTS-1:0]                          all_faults;
  logic [`EFH_NUM_FAULTS-1:0][15:0]                    cnt_arr;
  logic [`EFH_NUM_FAULTS-1:0][2:0]                     nent_arr;
  efh_stamp_t [`EFH_NUM_FAULTS-1:0][`EFH_HIST_DEPTH-1:0] ent_arr;
  logic [`EFH_NUM_FAULTS-1:0]                          occ_vec;
  logic [`EFH_NUM_FAULTS-1:0]                          sat_vec;

  // Main fault bits take the low indices, factory fault bits the high.
  assign all_faults = {factory_fault, main_fault};

  for (genvar g = 0; g < `EFH_NUM_FAULTS; g++) begin : g_fault
    efh_fault_slice u_slice (
      .pclk      (pclk),
      .presetn   (presetn),
      .fault     (all_faults[g]),
      .now       (now),
      .count     (cnt_arr[g]),
      .ent_count (nent_arr[g]),
      .entries   (ent_arr[g]),
      .occur     (occ_vec[g]),
      .saturate  (sat_vec[g])
    );
  end

  // --------------------------------------------------------------------
  // Bus decode and fill sources
  // --------------------------------------------------------------------
  logic                 busy;
  logic                 acc;
  logic                 legal;
  logic [15:0]          wi;
  logic [15:0]          boff;
  logic                 buf_hit;
  logic [11:0][15:0]    hdr_words;
  logic [8:0]           cidx;
  logic [15:0]          cnt_first_val;
  logic                 hsel_ok;
  logic [2:0]           nent_sel;
  efh_stamp_t           hent;
  logic [3:0][15:0]     hist_words;
  logic [15:0]          hist_first_word;

  // The buffer is only consistent when no load is running, so the bus
  // waits while one is; reads also need one idle cycle of captured data.
  assign busy    = (st.eng == EFH_ENG_RUN) || st.pend;
  assign pready  = !busy && st.fresh;
  assign acc     = psel && penable && pready;
  assign legal   = (paddr[`EFH_ADDR_HIGH] == '0) &&
                   (paddr[`EFH_ADDR_LANE] == '0);
  assign wi      = paddr[`EFH_WIDX];
  assign boff    = wi - `EFH_IDX_BUF;
  assign buf_hit = legal && (wi >= `EFH_IDX_BUF) &&
                   (boff < 16'(BUF_WORDS));

  // Header layout, word 0 on the right.
  assign hdr_words = {hdr.post_count, hdr.sample_period,
                      hdr.words_per_sample, hdr.sample_count,
                      hdr.sel_mask[47:32], hdr.sel_mask[63:48],
                      hdr.sel_mask[15:0], hdr.sel_mask[31:16],
                      hdr.trig.date[15:0], hdr.trig.date[31:16],
                      hdr.trig.tod[15:0], hdr.trig.tod[31:16]};

  // Counter word for the buffer slot in flight; past index 63 reads zero.
  assign cidx = {1'b0, st.cnt_first} + {1'b0, st.pk};
  assign cnt_first_val = (st.cnt_first < 8'(`EFH_NUM_FAULTS)) ?
                         cnt_arr[st.cnt_first[5:0]] : 16'h0000;

  // History of the selected fault; an index past 63 shows nothing.
  assign hsel_ok  = st.hidx < 16'(`EFH_NUM_FAULTS);
  assign nent_sel = hsel_ok ? nent_arr[st.hidx[5:0]] : 3'h0;
  assign hent     = hsel_ok ? ent_arr[st.hidx[5:0]][st.pk[4:2]] : '0;
  assign hist_words = {hent.tod[15:0], hent.tod[31:16],
                       hent.date[15:0], hent.date[31:16]};
  assign hist_first_word = hsel_ok ?
                           ent_arr[st.hidx[5:0]][0].date[31:16] : 16'h0000;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    logic [`EFH_IRQ_BITS-1:0] ev;
    logic                     ld_go;
    efh_kind_t                ld_kind;
    logic [7:0]               ld_len;
    logic [15:0]              fill;
    logic                     reg_hit;
    logic [31:0]              rd;
    ev      = '0;
    ld_go   = 1'b0;
    ld_kind = EFH_LD_HDR;
    ld_len  = 8'h00;
    fill    = 16'h0000;
    reg_hit = 1'b0;
    rd      = '0;
    next_st = st;

    // Events that feed the interrupt status.
    next_st.cap_done_q = (cap_state == EFH_CAP_DONE);
    ev[`EFH_IRQ_CAP]   = (cap_state == EFH_CAP_DONE) && !st.cap_done_q;
    ev[`EFH_IRQ_FAULT] = |occ_vec;
    ev[`EFH_IRQ_SAT]   = |sat_vec;

    // Second stage: write the word whose address went out last cycle.
    next_st.pend = 1'b0;
    if (st.pend) begin
      unique case (st.pkind)
        EFH_LD_HDR:  fill = hdr_words[st.pk[3:0]];
        EFH_LD_SAMP: fill = samp_rdata;
        EFH_LD_CNT:  fill = (cidx < 9'(`EFH_NUM_FAULTS)) ?
                            cnt_arr[cidx[5:0]] : 16'h0000;
        EFH_LD_HIST: fill = hist_words[st.pk[1:0]];
      endcase
      next_st.bufw[st.pk] = fill;
      if (st.eng == EFH_ENG_IDLE) begin
        ev[`EFH_IRQ_LOAD] = 1'b1;
      end
    end

    // First stage: step through the words of the load.
    if (st.eng == EFH_ENG_RUN) begin
      next_st.pend  = 1'b1;
      next_st.pk    = st.k;
      next_st.pkind = st.kind;
      next_st.k     = st.k + 8'h01;
      if (st.k == st.len - 8'h01) begin
        next_st.eng = EFH_ENG_IDLE;
      end
    end

    // Register writes; the bus stalls while busy, so no load is running.
    if (acc && pwrite && legal) begin
      case (wi)
        `EFH_IDX_HDR_CMD: begin
          ld_go   = (pwdata[15:0] == `EFH_CMD_GO);
          ld_kind = EFH_LD_HDR;
          ld_len  = `EFH_HDR_WORDS;
        end
        `EFH_IDX_SAMP_CMD: begin
          ld_go           = 1'b1;
          ld_kind         = EFH_LD_SAMP;
          next_st.samp_no = pwdata[15:0];
          ld_len = (hdr.words_per_sample > 16'(BUF_WORDS)) ?
                   BUF_LEN : hdr.words_per_sample[7:0];
        end
        `EFH_IDX_CNT_CMD: begin
          ld_go             = 1'b1;
          ld_kind           = EFH_LD_CNT;
          next_st.cnt_first = pwdata[`EFH_CNT_FIRST];
          ld_len = (pwdata[`EFH_CNT_NUM] > BUF_LEN) ?
                   BUF_LEN : pwdata[`EFH_CNT_NUM];
        end
        `EFH_IDX_HIST_CMD: begin
          ld_go   = (pwdata[15:0] == `EFH_CMD_GO);
          ld_kind = EFH_LD_HIST;
          ld_len  = `EFH_HIST_WORDS;
        end
        `EFH_IDX_HIST_IDX: next_st.hidx = pwdata[15:0];
        `EFH_IDX_IRQ_MASK: next_st.irq_msk = pwdata[`EFH_IRQ_BITS-1:0];
        `EFH_IDX_IRQ_STAT: next_st.irq_st =
                             st.irq_st & ~pwdata[`EFH_IRQ_BITS-1:0];
        default: ;
      endcase
    end

    // Start a load; an empty one only reports completion.
    if (ld_go) begin
      if (ld_len != 8'h00) begin
        next_st.eng  = EFH_ENG_RUN;
        next_st.kind = ld_kind;
        next_st.k    = 8'h00;
        next_st.len  = ld_len;
      end else begin
        ev[`EFH_IRQ_LOAD] = 1'b1;
      end
    end

    // A new event wins over a clear in the same cycle.
    next_st.irq_st = next_st.irq_st | ev;

    // Read data is captured every selected cycle for the next edge.
    if (buf_hit) begin
      rd[15:0] = st.bufw[boff[7:0]];
      reg_hit  = 1'b1;
    end else if (legal) begin
      reg_hit = 1'b1;
      case (wi)
        `EFH_IDX_STATE:    rd[1:0]  = cap_state;
        `EFH_IDX_HIST_IDX: rd[15:0] = st.hidx;
        `EFH_IDX_HIST_CNT: rd[2:0]  = nent_sel;
        `EFH_IDX_IRQ_STAT: rd[`EFH_IRQ_BITS-1:0] = st.irq_st;
        `EFH_IDX_IRQ_MASK: rd[`EFH_IRQ_BITS-1:0] = st.irq_msk;
        `EFH_IDX_HDR_CMD, `EFH_IDX_SAMP_CMD,
        `EFH_IDX_HIST_CMD, `EFH_IDX_CNT_CMD: rd = '0;
        default: reg_hit = 1'b0;
      endcase
    end
    if (psel) begin
      next_st.prdata = reg_hit ? rd : '0;
    end
    next_st.fresh = !busy;
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs.
  assign prdata  = st.prdata;
  assign pslverr = acc && !buf_hit && !(legal && (
                   wi == `EFH_IDX_STATE    || wi == `EFH_IDX_HDR_CMD  ||
                   wi == `EFH_IDX_SAMP_CMD || wi == `EFH_IDX_HIST_IDX ||
                   wi == `EFH_IDX_HIST_CNT || wi == `EFH_IDX_HIST_CMD ||
                   wi == `EFH_IDX_IRQ_STAT || wi == `EFH_IDX_IRQ_MASK ||
                   wi == `EFH_IDX_CNT_CMD));
  assign irq     = |(st.irq_st & st.irq_msk);
  assign samp_req.rd     = (st.eng == EFH_ENG_RUN) &&
                           (st.kind == EFH_LD_SAMP);
  assign samp_req.sample = st.samp_no;
  assign samp_req.word   = st.k;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  logic wr_hdr;
  logic wr_samp;
  logic wr_cnt;
  logic wr_hist;
  assign wr_hdr  = acc && pwrite && legal && wi == `EFH_IDX_HDR_CMD &&
                   pwdata[15:0] == `EFH_CMD_GO;
  assign wr_samp = acc && pwrite && legal && wi == `EFH_IDX_SAMP_CMD;
  assign wr_cnt  = acc && pwrite && legal && wi == `EFH_IDX_CNT_CMD;
  assign wr_hist = acc && pwrite && legal && wi == `EFH_IDX_HIST_CMD &&
                   pwdata[15:0] == `EFH_CMD_GO;

  property p_state_read;
    @(posedge pclk) disable iff (!presetn)
    acc && !pwrite && legal && wi == `EFH_IDX_STATE |->
      prdata == {30'h0000_0000, $past(cap_state)};
  endproperty
  a_state_read: assert property (p_state_read)
    else $error("Logger state read does not match the capture state.");

  property p_hdr_busy;
    @(posedge pclk) disable iff (!presetn)
    wr_hdr |=> busy [*8] ##1 busy [*5] ##1 !busy;
  endproperty
  a_hdr_busy: assert property (p_hdr_busy)
    else $error("Header load did not take twelve words.");

  property p_hdr_stamp;
    @(posedge pclk) disable iff (!presetn)
    wr_hdr |-> ##13 (st.bufw[0] == $past(hdr.trig.tod[31:16], 11)) &&
      (st.bufw[4] == $past(hdr.sel_mask[31:16], 7));
  endproperty
  a_hdr_stamp: assert property (p_hdr_stamp)
    else $error("Header stamp or mask word misplaced.");

  property p_hdr_count;
    @(posedge pclk) disable iff (!presetn)
    wr_hdr |-> ##14 (st.bufw[8] == $past(hdr.sample_count, 4)) &&
      (st.bufw[11] == $past(hdr.post_count, 1));
  endproperty
  a_hdr_count: assert property (p_hdr_count)
    else $error("Header count words misplaced.");

  property p_samp_req;
    @(posedge pclk) disable iff (!presetn)
    wr_samp && hdr.words_per_sample != 16'h0000 |=>
      samp_req.rd && samp_req.word == 8'h00 &&
      samp_req.sample == $past(pwdata[15:0]);
  endproperty
  a_samp_req: assert property (p_samp_req)
    else $error("Sample request did not follow the select write.");

  property p_samp_word;
    @(posedge pclk) disable iff (!presetn)
    samp_req.rd && samp_req.word == 8'h00 |-> ##2
      st.bufw[0] == $past(samp_rdata, 1);
  endproperty
  a_samp_word: assert property (p_samp_word)
    else $error("First sample word not in buffer word 0.");

  property p_fault_map;
    @(posedge pclk) disable iff (!presetn)
    $rose(factory_fault[0]) && cnt_arr[32] != `EFH_CNT_SAT |=>
      cnt_arr[32] == $past(cnt_arr[32]) + 16'h0001;
  endproperty
  a_fault_map: assert property (p_fault_map)
    else $error("Factory fault bit 0 not counted at index 32.");

  property p_cnt_load;
    @(posedge pclk) disable iff (!presetn)
    wr_cnt && pwdata[`EFH_CNT_NUM] != 8'h00 |-> ##3
      st.bufw[0] == $past(cnt_first_val, 1);
  endproperty
  a_cnt_load: assert property (p_cnt_load)
    else $error("First counter not loaded into buffer word 0.");

  property p_hcount_read;
    @(posedge pclk) disable iff (!presetn)
    acc && !pwrite && legal && wi == `EFH_IDX_HIST_CNT |->
      prdata == {29'h0000_0000, $past(nent_sel)} && $past(nent_sel) <= 3'h6;
  endproperty
  a_hcount_read: assert property (p_hcount_read)
    else $error("Entry count read is wrong.");

  property p_hist_len;
    @(posedge pclk) disable iff (!presetn)
    wr_hist |=> st.len == `EFH_HIST_WORDS && st.kind == EFH_LD_HIST;
  endproperty
  a_hist_len: assert property (p_hist_len)
    else $error("History load is not six pairs long.");

  property p_hist_first;
    @(posedge pclk) disable iff (!presetn)
    wr_hist |-> ##3 st.bufw[0] == $past(hist_first_word, 1);
  endproperty
  a_hist_first: assert property (p_hist_first)
    else $error("Oldest date high word not first in buffer.");

  property p_buf_hold;
    @(posedge pclk) disable iff (!presetn)
    !st.pend |=> $stable(st.bufw);
  endproperty
  a_buf_hold: assert property (p_buf_hold)
    else $error("Buffer changed without a load.");

  c_hdr:  cover property (@(posedge pclk) disable iff (!presetn) wr_hdr);
  c_samp: cover property (@(posedge pclk) disable iff (!presetn)
                          wr_samp ##1 samp_req.rd);
  c_hist: cover property (@(posedge pclk) disable iff (!presetn)
                          wr_hist ##[1:30] irq);
endmodule : efh_readout

// [shared/efh_regs.svh]
`ifndef EFH_REGS_SVH
`define EFH_REGS_SVH

// ----------------------------------------------------------------------
// Register word indices; the byte address is four times the index.
// ----------------------------------------------------------------------
`define EFH_IDX_STATE     16'hA489
`define EFH_IDX_HDR_CMD   16'hA48A
`define EFH_IDX_SAMP_CMD  16'hA48B
`define EFH_IDX_HIST_IDX  16'hA48C
`define EFH_IDX_HIST_CNT  16'hA48D
`define EFH_IDX_HIST_CMD  16'hA48E
`define EFH_IDX_IRQ_STAT  16'hA48F
`define EFH_IDX_IRQ_MASK  16'hA490
`define EFH_IDX_CNT_CMD   16'hA491
`define EFH_IDX_BUF       16'hA494
`define EFH_WIDX          17:2
`define EFH_ADDR_HIGH     31:18
`define EFH_ADDR_LANE     1:0

// ----------------------------------------------------------------------
// Fields, sizes and reset values.
// ----------------------------------------------------------------------
`define EFH_CMD_GO        16'h0001
`define EFH_CNT_FIRST     7:0
`define EFH_CNT_NUM       15:8
`define EFH_HDR_WORDS     8'h0C
`define EFH_HIST_WORDS    8'h18
`define EFH_NUM_FAULTS    64
`define EFH_HIST_DEPTH    6
`define EFH_CNT_SAT       16'hFFFE
`define EFH_IRQ_BITS      4
`define EFH_IRQ_LOAD      0
`define EFH_IRQ_CAP       1
`define EFH_IRQ_FAULT     2
`define EFH_IRQ_SAT       3
`define EFH_RST_HIST_IDX  16'h0000
`define EFH_RST_IRQ_MASK  4'h0
`endif

// [shared/efh_pkg.sv]
package efh_pkg;
  // Date and time of day as the logger keeps them.
  typedef struct packed {
    logic [31:0] date;
    logic [31:0] tod;
  } efh_stamp_t;

  // Capture summary presented by the logger.
  typedef struct packed {
    efh_stamp_t  trig;
    logic [63:0] sel_mask;
    logic [15:0] sample_count;
    logic [15:0] words_per_sample;
    logic [15:0] sample_period;
    logic [15:0] post_count;
  } efh_hdr_t;

  // Logger capture state as reported by the capture side.
  typedef enum logic [1:0] {
    EFH_CAP_IDLE = 2'h0,
    EFH_CAP_WAIT = 2'h1,
    EFH_CAP_RUN  = 2'h2,
    EFH_CAP_DONE = 2'h3
  } efh_cap_t;

  typedef enum logic [1:0] {
    EFH_ENG_IDLE = 2'b01,
    EFH_ENG_RUN  = 2'b10
  } efh_eng_t;

  typedef enum logic [3:0] {
    EFH_LD_HDR  = 4'b0001,
    EFH_LD_SAMP = 4'b0010,
    EFH_LD_CNT  = 4'b0100,
    EFH_LD_HIST = 4'b1000
  } efh_kind_t;

  // Word read request towards the sample memory.
  typedef struct packed {
    logic        rd;
    logic [15:0] sample;
    logic [7:0]  word;
  } efh_samp_req_t;
endpackage : efh_pkg

// [hw/efh_fault_slice.sv]
`timescale 1ns/10ps
`include "efh_regs.svh"
module efh_fault_slice
  import efh_pkg::*;
(
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          fault,
  input  wire efh_stamp_t                    now,
  output logic [15:0]                        count,
  output logic [2:0]                         ent_count,
  output efh_stamp_t [`EFH_HIST_DEPTH-1:0]   entries,
  output logic                               occur,
  output logic                               saturate
);
  typedef struct packed {
    logic                                prev;
    logic [15:0]                         cnt;
    logic [2:0]                          nent;
    efh_stamp_t [`EFH_HIST_DEPTH-1:0]    ent;
  } efh_slice_t;

  efh_slice_t st;
  efh_slice_t next_st;

  // A new occurrence is a rising edge of the fault level.
  assign occur     = fault && !st.prev;
  assign saturate  = occur && (st.cnt == `EFH_CNT_SAT - 16'h0001);
  assign count     = st.cnt;
  assign ent_count = st.nent;
  assign entries   = st.ent;

  // Counter and time stamp history update.
  always_comb begin
    next_st      = st;
    next_st.prev = fault;
    if (occur) begin
      if (st.cnt != `EFH_CNT_SAT) begin
        next_st.cnt = st.cnt + 16'h0001;
      end
      if (st.nent < 3'(`EFH_HIST_DEPTH)) begin
        next_st.ent[st.nent] = now;
        next_st.nent         = st.nent + 3'h1;
      end else begin
        next_st.ent = {now, st.ent[`EFH_HIST_DEPTH-1:1]};
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  property p_cnt_inc;
    @(posedge pclk) disable iff (!presetn)
    occur && (count != `EFH_CNT_SAT) |=> count == $past(count) + 16'h0001;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc)
    else $error("Occurrence counter did not advance by one.");

  property p_cnt_sat;
    @(posedge pclk) disable iff (!presetn)
    count == `EFH_CNT_SAT |=> count == `EFH_CNT_SAT;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat)
    else $error("Saturated counter left 0xFFFE.");

  property p_hist_full;
    @(posedge pclk) disable iff (!presetn)
    occur && (ent_count == 3'(`EFH_HIST_DEPTH)) |=>
      (ent_count == 3'(`EFH_HIST_DEPTH)) &&
      (entries[`EFH_HIST_DEPTH-1] == $past(now));
  endproperty
  a_hist_full: assert property (p_hist_full)
    else $error("Newest stamp not kept in the last history slot.");
endmodule : efh_fault_slice

// [testbench/efh_readout_bench.sv]
`timescale 1ns/10ps
`include "efh_regs.svh"
module efh_readout_bench;
  import efh_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic          err;
  logic [31:0]   paddr, pwdata, prdata, rd, t;
  logic [63:0]   flt, s;
  logic [15:0]   samp_rdata, hx [12];
  efh_cap_t      cap_state;
  efh_hdr_t      hdr;
  efh_stamp_t    now;
  efh_samp_req_t samp_req;
  int            fails, total_checks, n;

  efh_readout #(.BUF_WORDS(128)) u_efh_readout (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cap_state(cap_state), .hdr(hdr),
    .main_fault(flt[31:0]), .factory_fault(flt[63:32]), .now(now),
    .samp_req(samp_req), .samp_rdata(samp_rdata), .irq(irq));

  // Sample memory answers one cycle later with sample and word number.
  always @(posedge pclk) samp_rdata <= {samp_req.sample[7:0], samp_req.word};

  // Free running clock of 20 ns.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ------------------------------------------------------------------
  // Bus and check tasks.
  // ------------------------------------------------------------------
  task print_verdict;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; waits a bounded time for pready.
  task apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {14'h0000, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    if (pready !== 1'b1) begin
      fails++;
      print_verdict;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Raises one fault bit with a known time stamp, then drops it.
  task pulse(input int b, input logic [31:0] v);
    now    <= '{date: v, tod: ~v};
    flt[b] <= 1'b1;
    repeat (3) @(posedge pclk);
    flt[b] <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse

  // ------------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, flt} = '0;
    now = '0;
    cap_state = EFH_CAP_DONE;
    hdr = {32'h9ABC_DEF0, 32'h1234_5678, 64'h0011_2233_4455_6677,
           16'h000C, 16'h0004, 16'h000A, 16'h0003};
    hx = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0, 16'h4455, 16'h6677,
           16'h0011, 16'h2233, 16'h000C, 16'h0004, 16'h000A, 16'h0003};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `EFH_IDX_STATE, 0);
    chk("state", 32'h3, rd);
    cap_state <= EFH_CAP_WAIT;
    apb(1'b0, `EFH_IDX_STATE, 0);
    chk("state", 32'h1, rd);
    apb(1'b1, `EFH_IDX_HDR_CMD, 1);
    for (int k = 0; k < 12; k++) begin
      apb(1'b0, `EFH_IDX_BUF + 16'(k), 0);
      chk("hdr", {16'h0000, hx[k]}, rd);
    end
    apb(1'b1, `EFH_IDX_SAMP_CMD, 5);
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, `EFH_IDX_BUF + 16'(k), 0);
      chk("samp", {16'h0000, 8'h05, 8'(k)}, rd);
    end
    apb(1'b0, `EFH_IDX_BUF + 16'h0004, 0);
    chk("keep", 32'h4455, rd);
    apb(1'b1, `EFH_IDX_IRQ_MASK, 4);
    pulse(1, 32'hA000_0001);
    pulse(1, 32'hB000_0002);
    pulse(32, 32'hC000_0003);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, `EFH_IDX_IRQ_STAT, 32'hF);
    @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, `EFH_IDX_CNT_CMD, 32'h2001);
    apb(1'b0, `EFH_IDX_BUF, 0);
    chk("cnt1", 32'h2, rd);
    apb(1'b0, `EFH_IDX_BUF + 16'h001F, 0);
    chk("cnt32", 32'h1, rd);
    apb(1'b1, `EFH_IDX_HIST_IDX, 1);
    apb(1'b0, `EFH_IDX_HIST_IDX, 0);
    chk("hidx", 32'h1, rd);
    apb(1'b0, `EFH_IDX_HIST_CNT, 0);
    chk("entries", 32'h2, rd);
    // Only the load-done interrupt is unmasked for the history load.
    apb(1'b1, `EFH_IDX_IRQ_MASK, 1);
    apb(1'b1, `EFH_IDX_IRQ_STAT, 32'hF);
    @(posedge pclk);
    chk("irq_load", 32'h0, {31'h0, irq});
    apb(1'b1, `EFH_IDX_HIST_CMD, 1);
    for (int k = 0; k < 8; k++) begin
      t = (k < 4) ? 32'hA000_0001 : 32'hB000_0002;
      s = {t, ~t};
      apb(1'b0, `EFH_IDX_BUF + 16'(k), 0);
      chk("hist", {16'h0000, s[63-16*(k%4) -: 16]}, rd);
    end
    chk("irq_load", 32'h1, {31'h0, irq});
    apb(1'b0, 16'hA492, 0);
    chk("unmapped", 32'h1, {31'h0, err});
    print_verdict;
  end
endmodule : efh_readout_bench
